// >>> rtcac_pkg.sv
// shared constants and carriers for the rtc alarm and control block
package rtcac_pkg;

    localparam int ADDR_W = 12;
    localparam int DIV_W  = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ALARM_SECONDS = 8'he8;
    localparam logic [7:0] IDX_ALARM_MINUTES = 8'he9;
    localparam logic [7:0] IDX_ALARM_HOURS   = 8'hea;
    localparam logic [7:0] IDX_ALARM_WEEKDAY = 8'heb;
    localparam logic [7:0] IDX_ALARM_ENABLES = 8'hec;
    localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hed;

    // control and status bit positions
    localparam int CTRL_ALARM    = 7;
    localparam int CTRL_INT_EN   = 6;
    localparam int CTRL_BCD      = 5;
    localparam int CTRL_CLK_SEL  = 4;
    localparam int CTRL_MAINS    = 3;
    localparam int CTRL_SLEEP    = 1;
    localparam int CTRL_UNLOCK   = 0;

    // alarm field enable positions
    localparam int EN_SEC = 0;
    localparam int EN_MIN = 1;
    localparam int EN_HRS = 2;
    localparam int EN_DOW = 3;

    // set point ranges
    localparam logic [3:0] ONES_MAX     = 4'h9;
    localparam logic [3:0] MIN_TENS_MAX = 4'h5;
    localparam logic [7:0] MIN_BIN_MAX  = 8'h3b;
    localparam logic [3:0] HRS_TENS_MAX = 4'h2;
    localparam logic [7:0] HRS_BIN_MAX  = 8'h17;
    localparam logic [3:0] DOW_MIN      = 4'h1;
    localparam logic [3:0] DOW_MAX      = 4'h7;

    // time base prescale figures, in source cycles per second
    localparam int XTAL_HZ  = 32768;
    localparam int MAINS_60 = 60;
    localparam int MAINS_50 = 50;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hrs;
        logic [3:0] dow;
    } rtcac_time_t;

    // state that survives a system reset, cleared only at power-on
    typedef struct packed {
        logic [7:0] alarm_sec;
        logic [7:0] alarm_min;
        logic [7:0] alarm_hrs;
        logic [3:0] alarm_dow;
        logic       alarm_flag;
        logic       bcd;
        logic       clk_sel;
        logic       mains_rate;
        logic       sleep_flag;
    } rtcac_keep_t;

    // state cleared by a system reset
    typedef struct packed {
        logic [3:0]       enables;
        logic             int_en;
        logic             unlock;
        logic [DIV_W-1:0] div_cnt;
        logic [1:0]       xtal_sync;
        logic [1:0]       mains_sync;
        logic             xtal_prev;
        logic             mains_prev;
        logic             tick;
        logic             wake;
        logic [7:0]       rdata;
        logic             slverr;
    } rtcac_clr_t;

endpackage

// >>> rtcac_alarm_ctrl.sv
// rtc alarm compare, control register, prescale divider and apb slave
//
// What this block does
// - alarm minutes: bcd tens 0-5 high nibble, ones low; binary 0-59
// - alarm hours: bcd tens 0-2 high nibble, ones low; binary 0-23
// - alarm weekday lives in low nibble, 1 to 7; upper nibble reads zero
// - weekday set point writable only while unlocked; reset leaves it alone
// - alarm minutes and hours always read/write, kept across system reset
// - system reset clears alarm enables; upper nibble read-only zero
// - enable bits 3..0 include weekday, hours, minutes, seconds in compare
// - control bit 7 shows pending alarm; control read clears it and interrupt
// - alarm flag re-evaluated only on relock or on a count increment
// - any control write restarts the prescale divider
// - control bit 1 marks alarm wake from sleep; cleared by control read
// - control bit 6 gates alarm interrupt; reset clears it
// - control bit 5 selects decimal coding for counts and set points
// - bit 4 low: crystal on, divide by 32768; high: oscillator off, mains
// - with mains, bit 3 low means 60 Hz and high 50 Hz; one tick a second
// - control bit 0 unlocks count writes and halts counting; reset clears
// - reset clears control bits 6 and 0, keeps 7,5,4,3,1; bit 2 reads 0
// - alarm seconds: bcd tens 0-5 and ones, or binary 0-59; always r/w
`timescale 1ns/10ps

module rtcac_alarm_ctrl
    import rtcac_pkg::*;
#(
    parameter int XTAL_DIVIDE = XTAL_HZ
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              por_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              xtal_clk_in,
    input  wire logic              mains_in,
    input  wire logic              sleep_mode,
    input  wire logic              count_step,
    input  wire rtcac_time_t       now,
    output logic                   second_tick,
    output logic                   osc_enable,
    output logic                   count_write_enable,
    output logic                   bcd_mode,
    output logic                   alarm_irq,
    output logic                   wake_request
);

    if (XTAL_DIVIDE < 2 || XTAL_DIVIDE > (1 << DIV_W)) begin : g_check
        $error("XTAL_DIVIDE out of range for the prescale counter");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic setpoint_ok(input logic [7:0] v,
                                         input logic [3:0] tens_max,
                                         input logic [7:0] bin_max,
                                         input logic       bcd);
        if (bcd) begin
            setpoint_ok = (v[7:4] <= tens_max) && (v[3:0] <= ONES_MAX);
        end else begin
            setpoint_ok = (v <= bin_max);
        end
    endfunction

    function automatic logic field_hit(input logic       en,
                                       input logic [7:0] setpoint,
                                       input logic [7:0] count,
                                       input logic       legal);
        field_hit = !en || (legal && setpoint == count);
    endfunction

    function automatic logic [DIV_W-1:0] prescale_last(input logic clk_sel,
                                                       input logic mains_rate);
        if (!clk_sel) begin
            prescale_last = DIV_W'(XTAL_DIVIDE - 1);
        end else if (mains_rate) begin
            prescale_last = DIV_W'(MAINS_50 - 1);
        end else begin
            prescale_last = DIV_W'(MAINS_60 - 1);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    rtcac_keep_t keep;
    rtcac_keep_t next_keep;
    rtcac_clr_t  clr;
    rtcac_clr_t  next_clr;

    logic        sys_rst_n;
    logic [7:0]  reg_idx;
    logic        idx_mapped;
    logic        setup_phase;
    logic        wr_access;
    logic        rd_access;
    logic        ctrl_write;
    logic        ctrl_read;
    logic        relock;
    logic        src_edge;
    logic        alarm_match;
    logic        eval_now;
    logic        alarm_set;
    logic [7:0]  read_value;
    logic [7:0]  ctrl_value;

    assign sys_rst_n   = presetn & por_n;
    assign reg_idx     = paddr[9:2];
    assign idx_mapped  = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00) &&
                         (reg_idx >= IDX_ALARM_SECONDS) && (reg_idx <= IDX_CLOCK_CONTROL);
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite && idx_mapped;
    assign rd_access   = psel && penable && !pwrite && idx_mapped;
    assign ctrl_write  = wr_access && reg_idx == IDX_CLOCK_CONTROL;
    assign ctrl_read   = rd_access && reg_idx == IDX_CLOCK_CONTROL;
    assign relock      = ctrl_write && clr.unlock && !pwdata[CTRL_UNLOCK];

    // source edge of crystal or mains, after synchroniser
    assign src_edge = keep.clk_sel ? (clr.mains_sync[1] && !clr.mains_prev)
                                   : (clr.xtal_sync[1] && !clr.xtal_prev);

    // every enabled field must match, at least one enabled
    assign alarm_match = (clr.enables != 4'h0) &&
        field_hit(clr.enables[EN_SEC], keep.alarm_sec, now.sec,
                  setpoint_ok(keep.alarm_sec, MIN_TENS_MAX, MIN_BIN_MAX, keep.bcd)) &&
        field_hit(clr.enables[EN_MIN], keep.alarm_min, now.min,
                  setpoint_ok(keep.alarm_min, MIN_TENS_MAX, MIN_BIN_MAX, keep.bcd)) &&
        field_hit(clr.enables[EN_HRS], keep.alarm_hrs, now.hrs,
                  setpoint_ok(keep.alarm_hrs, HRS_TENS_MAX, HRS_BIN_MAX, keep.bcd)) &&
        field_hit(clr.enables[EN_DOW], {4'h0, keep.alarm_dow}, {4'h0, now.dow},
                  keep.alarm_dow >= DOW_MIN && keep.alarm_dow <= DOW_MAX);

    // compare only on a count step or a relock
    assign eval_now  = count_step || relock;
    assign alarm_set = eval_now && alarm_match;

    assign ctrl_value = {keep.alarm_flag, clr.int_en, keep.bcd, keep.clk_sel,
                         keep.mains_rate, 1'b0, keep.sleep_flag, clr.unlock};

    always_comb begin
        read_value = 8'h00;
        unique case (reg_idx)
            IDX_ALARM_SECONDS: read_value = keep.alarm_sec;
            IDX_ALARM_MINUTES: read_value = keep.alarm_min;
            IDX_ALARM_HOURS:   read_value = keep.alarm_hrs;
            IDX_ALARM_WEEKDAY: read_value = {4'h0, keep.alarm_dow};
            IDX_ALARM_ENABLES: read_value = {4'h0, clr.enables};
            IDX_CLOCK_CONTROL: read_value = ctrl_value;
            default:           read_value = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_keep = keep;
        next_clr  = clr;

        next_clr.xtal_sync  = {clr.xtal_sync[0], xtal_clk_in};
        next_clr.mains_sync = {clr.mains_sync[0], mains_in};
        next_clr.xtal_prev  = clr.xtal_sync[1];
        next_clr.mains_prev = clr.mains_sync[1];

        // divider: a control write re-phases the second boundary
        next_clr.tick = 1'b0;
        if (ctrl_write) begin
            next_clr.div_cnt = '0;
        end else if (!clr.unlock && src_edge) begin
            if (clr.div_cnt >= prescale_last(keep.clk_sel, keep.mains_rate)) begin
                next_clr.div_cnt = '0;
                next_clr.tick    = 1'b1;
            end else begin
                next_clr.div_cnt = clr.div_cnt + DIV_W'(1);
            end
        end

        if (wr_access) begin
            unique case (reg_idx)
                IDX_ALARM_SECONDS: next_keep.alarm_sec = pwdata[7:0];
                IDX_ALARM_MINUTES: next_keep.alarm_min = pwdata[7:0];
                IDX_ALARM_HOURS:   next_keep.alarm_hrs = pwdata[7:0];
                IDX_ALARM_WEEKDAY: begin
                    if (clr.unlock) begin
                        next_keep.alarm_dow = pwdata[3:0];
                    end
                end
                IDX_ALARM_ENABLES: next_clr.enables = pwdata[3:0];
                IDX_CLOCK_CONTROL: begin
                    next_clr.int_en      = pwdata[CTRL_INT_EN];
                    next_keep.bcd        = pwdata[CTRL_BCD];
                    next_keep.clk_sel    = pwdata[CTRL_CLK_SEL];
                    next_keep.mains_rate = pwdata[CTRL_MAINS];
                    next_clr.unlock      = pwdata[CTRL_UNLOCK];
                end
                default: ;
            endcase
        end

        // read clears first so a same-cycle alarm still wins
        if (ctrl_read) begin
            next_keep.alarm_flag = 1'b0;
            next_keep.sleep_flag = 1'b0;
        end
        next_clr.wake = 1'b0;
        if (alarm_set) begin
            next_keep.alarm_flag = 1'b1;
            if (sleep_mode) begin
                next_keep.sleep_flag = 1'b1;
                next_clr.wake        = 1'b1;
            end
        end

        // read data captured in setup so prdata comes from a flop
        if (setup_phase) begin
            next_clr.rdata  = read_value;
            next_clr.slverr = !idx_mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; retained fields survive a system reset by design

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            keep <= '0;
        end else begin
            keep <= next_keep;
        end
    end

    always_ff @(posedge pclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            clr <= '0;
        end else begin
            clr <= next_clr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata             = {24'h000000, clr.rdata};
    assign pready             = 1'b1;
    assign pslverr            = clr.slverr && psel && penable;
    assign second_tick        = clr.tick;
    assign osc_enable         = !keep.clk_sel;
    assign count_write_enable = clr.unlock;
    assign bcd_mode           = keep.bcd;
    assign alarm_irq          = keep.alarm_flag && clr.int_en;
    assign wake_request       = clr.wake;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_ctrl_read;
        psel && !penable && !pwrite && idx_mapped && reg_idx == IDX_CLOCK_CONTROL
        ##1 psel && penable;
    endsequence

    sequence s_quiet_cycle;
        !count_step && !relock;
    endsequence

    a_read_clears_flag: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        s_ctrl_read ##0 !alarm_set |=> !keep.alarm_flag && !alarm_irq)
        else $error("control read did not clear the alarm flag");

    a_read_clears_sleep: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        s_ctrl_read ##0 !alarm_set |=> !keep.sleep_flag)
        else $error("control read did not clear the sleep flag");

    a_flag_only_eval: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        !keep.alarm_flag ##0 s_quiet_cycle |=> !keep.alarm_flag)
        else $error("alarm flag rose without evaluation");

    a_match_sets_irq: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        alarm_set && clr.int_en && !ctrl_write |=> keep.alarm_flag && alarm_irq)
        else $error("match did not raise the alarm");

    a_none_enabled: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        clr.enables == 4'h0 |-> !alarm_set)
        else $error("alarm with no field enabled");

    a_irq_gated_off: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        !clr.int_en && keep.alarm_flag |-> !alarm_irq)
        else $error("interrupt while disabled");

    a_weekday_locked: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        wr_access && reg_idx == IDX_ALARM_WEEKDAY && !clr.unlock |=> $stable(keep.alarm_dow))
        else $error("locked weekday set point changed");

    a_weekday_upper: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        setup_phase && idx_mapped && reg_idx == IDX_ALARM_WEEKDAY |=> prdata[7:4] == 4'h0)
        else $error("weekday upper nibble not zero");

    a_minutes_always: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        wr_access && reg_idx == IDX_ALARM_MINUTES |=> keep.alarm_min == $past(pwdata[7:0]))
        else $error("minutes write lost");

    a_write_restarts: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        ctrl_write |=> clr.div_cnt == '0 && !second_tick)
        else $error("control write did not restart divider");

    a_halt_unlocked: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        clr.unlock [*2] |-> !second_tick)
        else $error("tick while counter halted");

    a_tick_terminal: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        second_tick && $stable(keep.clk_sel) && $stable(keep.mains_rate)
        |-> $past(clr.div_cnt) == prescale_last(keep.clk_sel, keep.mains_rate))
        else $error("tick not at prescale terminal");

    a_osc_off_mains: assert property (@(posedge pclk) disable iff (!sys_rst_n)
        ctrl_write && pwdata[CTRL_CLK_SEL] |=> !osc_enable)
        else $error("oscillator left on with mains source");

endmodule

// >>> rtc_alarm_and_control_tb.sv
// self-checking bench for the rtc alarm and control block
`timescale 1ns/10ps

module rtc_alarm_and_control_tb
    import rtcac_pkg::*;
;
    // short crystal divide keeps the run brief
    localparam int DIV = 8;

    logic              pclk        = 1'b0;
    logic              presetn     = 1'b0;
    logic              por_n       = 1'b0;
    logic              psel        = 1'b0;
    logic              penable     = 1'b0;
    logic              pwrite      = 1'b0;
    logic [ADDR_W-1:0] paddr       = '0;
    logic [31:0]       pwdata      = '0;
    logic              xtal_clk_in = 1'b0;
    logic              mains_in    = 1'b0;
    logic              sleep_mode  = 1'b0;
    logic              count_step  = 1'b0;
    rtcac_time_t       now         = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              second_tick;
    logic              osc_enable;
    logic              count_write_enable;
    logic              bcd_mode;
    logic              alarm_irq;
    logic              wake_request;
    logic [31:0]       rd;
    logic              er;
    int                fail_count      = 0;
    int                samples_checked = 0;
    int                cycles          = 0;
    int                ticks           = 0;
    int                wakes           = 0;
    int                t0;

    rtcac_alarm_ctrl #(.XTAL_DIVIDE(DIV)) u_rtcac_alarm_ctrl (
        .pclk               (pclk),
        .presetn            (presetn),
        .por_n              (por_n),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .xtal_clk_in        (xtal_clk_in),
        .mains_in           (mains_in),
        .sleep_mode         (sleep_mode),
        .count_step         (count_step),
        .now                (now),
        .second_tick        (second_tick),
        .osc_enable         (osc_enable),
        .count_write_enable (count_write_enable),
        .bcd_mode           (bcd_mode),
        .alarm_irq          (alarm_irq),
        .wake_request       (wake_request)
    );

    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (second_tick === 1'b1) ticks++;
        if (wake_request === 1'b1) wakes++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // the access edge updates flops after this step; callers look one edge later
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask

    task expect_reg(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
        check(what, rd, exp);
    endtask

    task step();
        @(posedge pclk);
        count_step <= 1'b1;
        @(posedge pclk);
        count_step <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task sys_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // two cycles high and two low so the synchroniser never misses an edge
    task src(input logic mains, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (mains) mains_in <= 1'b1;
            else xtal_clk_in <= 1'b1;
            repeat (2) @(posedge pclk);
            if (mains) mains_in <= 1'b0;
            else xtal_clk_in <= 1'b0;
            @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_registers();
        expect_reg("enables", IDX_ALARM_ENABLES, 32'h0);
        expect_reg("control", IDX_CLOCK_CONTROL, 32'h0);
        check("osc_enable", osc_enable, 1'b1);
        wr(IDX_ALARM_MINUTES, 32'h59);
        wr(IDX_ALARM_HOURS, 32'h23);
        wr(IDX_ALARM_SECONDS, 32'h3b);
        wr(IDX_ALARM_ENABLES, 32'hff);
        expect_reg("minutes", IDX_ALARM_MINUTES, 32'h59);
        expect_reg("hours", IDX_ALARM_HOURS, 32'h23);
        expect_reg("seconds", IDX_ALARM_SECONDS, 32'h3b);
        expect_reg("enables", IDX_ALARM_ENABLES, 32'h0f);
        wr(IDX_ALARM_WEEKDAY, 32'h05);
        expect_reg("weekday locked", IDX_ALARM_WEEKDAY, 32'h0);
        wr(IDX_CLOCK_CONTROL, 32'h61);
        check("count_write_enable", count_write_enable, 1'b1);
        check("bcd_mode", bcd_mode, 1'b1);
        wr(IDX_ALARM_WEEKDAY, 32'hf6);
        expect_reg("weekday", IDX_ALARM_WEEKDAY, 32'h06);
        apb(1'b0, 12'h3b8, 32'h0);
        check("unmapped err", er, 1'b1);
        check("unmapped data", rd, 32'h0);
        sys_reset();
        expect_reg("control kept", IDX_CLOCK_CONTROL, 32'h20);
        check("count_write_enable", count_write_enable, 1'b0);
        expect_reg("minutes kept", IDX_ALARM_MINUTES, 32'h59);
        expect_reg("weekday kept", IDX_ALARM_WEEKDAY, 32'h06);
        expect_reg("enables clr", IDX_ALARM_ENABLES, 32'h0);
    endtask

    task t_alarm();
        now <= '{sec: 8'h00, min: 8'h59, hrs: 8'h23, dow: 4'h6};
        wr(IDX_CLOCK_CONTROL, 32'h60);
        wr(IDX_ALARM_ENABLES, 32'h02);
        step();
        check("irq", alarm_irq, 1'b1);
        expect_reg("flag", IDX_CLOCK_CONTROL, 32'he0);
        check("irq cleared", alarm_irq, 1'b0);
        expect_reg("flag clr", IDX_CLOCK_CONTROL, 32'h60);
        wr(IDX_CLOCK_CONTROL, 32'h20);
        step();
        check("irq gated", alarm_irq, 1'b0);
        expect_reg("flag gated", IDX_CLOCK_CONTROL, 32'ha0);
        wr(IDX_ALARM_ENABLES, 32'h06);
        now.hrs <= 8'h22;
        step();
        expect_reg("hrs miss", IDX_CLOCK_CONTROL, 32'h20);
        now.hrs <= 8'h23;
        wr(IDX_ALARM_ENABLES, 32'h0e);
        step();
        expect_reg("three hit", IDX_CLOCK_CONTROL, 32'ha0);
        wr(IDX_ALARM_ENABLES, 32'h00);
        step();
        expect_reg("none", IDX_CLOCK_CONTROL, 32'h20);
        wr(IDX_CLOCK_CONTROL, 32'h00);
        wr(IDX_ALARM_MINUTES, 32'h3b);
        now.min <= 8'h3b;
        wr(IDX_ALARM_ENABLES, 32'h02);
        step();
        expect_reg("binary hit", IDX_CLOCK_CONTROL, 32'h80);
        // 3b is not a legal decimal minute, so it must not match
        wr(IDX_CLOCK_CONTROL, 32'h20);
        step();
        expect_reg("bcd illegal", IDX_CLOCK_CONTROL, 32'h20);
        wr(IDX_CLOCK_CONTROL, 32'h21);
        wr(IDX_ALARM_ENABLES, 32'h08);
        expect_reg("no eval", IDX_CLOCK_CONTROL, 32'h21);
        wr(IDX_CLOCK_CONTROL, 32'h20);
        expect_reg("relock eval", IDX_CLOCK_CONTROL, 32'ha0);
        sleep_mode <= 1'b1;
        t0 = wakes;
        step();
        check("wake pulse", wakes - t0, 1);
        sleep_mode <= 1'b0;
        sys_reset();
        expect_reg("wake flag", IDX_CLOCK_CONTROL, 32'ha2);
        expect_reg("wake clr", IDX_CLOCK_CONTROL, 32'h20);
    endtask

    task t_divider();
        wr(IDX_CLOCK_CONTROL, 32'h00);
        t0 = ticks;
        src(1'b0, 2 * DIV);
        check("xtal ticks", ticks - t0, 2);
        src(1'b0, DIV - 2);
        wr(IDX_CLOCK_CONTROL, 32'h00);
        t0 = ticks;
        src(1'b0, DIV - 2);
        check("div restart", ticks - t0, 0);
        src(1'b0, 2);
        check("div restart", ticks - t0, 1);
        wr(IDX_CLOCK_CONTROL, 32'h01);
        t0 = ticks;
        src(1'b0, DIV);
        check("halted", ticks - t0, 0);
        wr(IDX_CLOCK_CONTROL, 32'h18);
        check("osc off", osc_enable, 1'b0);
        t0 = ticks;
        src(1'b1, 49);
        check("50 hz", ticks - t0, 0);
        src(1'b1, 1);
        check("50 hz", ticks - t0, 1);
        wr(IDX_CLOCK_CONTROL, 32'h10);
        t0 = ticks;
        src(1'b1, 59);
        check("60 hz", ticks - t0, 0);
        src(1'b1, 1);
        check("60 hz", ticks - t0, 1);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        por_n   <= 1'b1;
        presetn <= 1'b1;
        t_registers();
        t_alarm();
        t_divider();
        results();
    end
endmodule
